// ===== common/wwt_pkg.sv
// Package for the windowed timeout supervisor: register map, field positions,
// reset values and counts. Assumes a 125 MHz system clock and APB access.
`default_nettype none

package wwt_pkg;
    // Register byte offsets on the APB bus
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TC = 8'h04;
    localparam logic [7:0] OFF_FEED = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_WARN = 8'h10;
    localparam logic [7:0] OFF_WINDOW = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;
    localparam logic [7:0] OFF_RST_FLAG = 8'h20;

    // Control register fields
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_RST_EN = 1;
    localparam int unsigned CTRL_WIN_EN = 2;
    localparam int unsigned CTRL_CLK_SEL = 3;

    // Interrupt status and mask fields
    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_WARN = 0;
    localparam int unsigned INT_FAULT = 1;
    localparam int unsigned INT_TMO = 2;

    // Counter and reset values
    localparam int unsigned CNT_W = 24;
    localparam logic [23:0] TC_MIN = 24'h0000ff;
    localparam logic [23:0] TC_RST = 24'h0000ff;
    localparam logic [23:0] WARN_RST = 24'h000000;
    localparam logic [23:0] WINDOW_RST = 24'hffffff;
    localparam logic [23:0] CNT_RST = 24'h0000ff;

    // Fixed divide-by-four prescaler on the tick clock
    localparam int unsigned PRESC_W = 2;
    localparam logic [1:0] PRESC_LAST = 2'h3;

    // Feed sequence values
    localparam logic [7:0] FEED_FIRST = 8'haa;
    localparam logic [7:0] FEED_SECOND = 8'h55;

    // Length of the chip reset pulse in system clock cycles
    localparam int unsigned RST_HOLD_W = 5;
    localparam logic [4:0] RST_HOLD_CYCLES = 5'h10;

    // Pin synchroniser depth
    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic {
        FEED_IDLE,
        FEED_ARMED
    } wwt_feed_state_type;
endpackage : wwt_pkg

`default_nettype wire

// ===== rtl/wwt_tick_sync.sv
// Brings a tick clock pin into the system clock domain as a rising-edge pulse.
// Assumes the tick clock is much slower than the system clock.
`default_nettype none

module wwt_tick_sync (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Pin and pulse
    input wire logic tick_pin_in,
    output logic tick_rise_out
);
    logic [wwt_pkg::SYNC_STAGES-1:0] sync_r;
    logic level_r;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[wwt_pkg::SYNC_STAGES-2:0], tick_pin_in};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_r <= 1'b0;
            tick_rise_out <= 1'b0;
        end else begin
            tick_rise_out <= 1'b0;
            if (sync_r[1] == sync_r[2] && sync_r[2] != level_r) begin
                level_r <= sync_r[2];
                tick_rise_out <= sync_r[2];
            end
        end
    end
endmodule : wwt_tick_sync

`default_nettype wire

// ===== rtl/wwt_timeout_supervisor.sv
// Windowed timeout supervisor with APB register access, warning and fault
// interrupts, and a chip reset request. Assumes rst_n_in is the power-on reset
// and that the system resets the rest of the chip from chip_reset_out.
`default_nettype none

// Behaviour
// - Missing a valid feed before time-out requests a chip reset when reset is enabled, otherwise it sets the time-out interrupt.
// - In window mode a feed above the window value is a fault.
// - Warning interrupt when the counter reaches the programmed warning value.
// - Enable is set by software only; reset or watchdog event clears it.
// - A bad feed sequence gives a chip reset or an interrupt, as configured.
// - A readable flag records that the watchdog caused a chip reset.
// - The time-out counter is 24 bits, stepped by a tick prescaler.
// - Period is count plus one times four ticks, count at least 255.
// - The tick source is selectable between RC and watch oscillators.
// - A watchdog reset also starts the RC oscillator and flash initialisation.
module wwt_timeout_supervisor (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [wwt_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Tick clock pins
    input wire logic internal_rc_oscillator_in,
    input wire logic dedicated_watch_oscillator_in,
    // System outputs
    output logic irq_out,
    output logic chip_reset_out,
    output logic irc_start_out,
    output logic flash_init_out
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    logic [1:0] tick_rise;
    logic tick_sel;
    logic en_r, rst_en_r, win_en_r, clk_sel_r;
    logic [23:0] tc_r, warn_r, window_r, cnt_r;
    logic [1:0] presc_r;
    logic [wwt_pkg::INT_W-1:0] int_stat_r, int_mask_r, int_set;
    logic rst_flag_r;
    logic [4:0] hold_r;
    wwt_pkg::wwt_feed_state_type feed_st_r;
    logic acc, wr, feed_wr, feed_ok, bad_seq, win_fault, fault_ev;
    logic step, timeout_ev, warn_ev, reload, en_rise, wd_rst_ev, soft_clr;
    logic [23:0] tc_wdata;
    logic [31:0] rd_data;
    logic rd_err;

    // Both tick pins pass their own synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tick
            wwt_tick_sync u_sync (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .tick_pin_in(gi == 0 ? internal_rc_oscillator_in
                                     : dedicated_watch_oscillator_in),
                .tick_rise_out(tick_rise[gi])
            );
        end
    endgenerate

    assign tick_sel = clk_sel_r ? tick_rise[1] : tick_rise[0];

    // Bus decode: a transfer completes when pready is high in the access phase
    assign acc = psel_in & penable_in & pready_out;
    assign wr = acc & pwrite_in;
    assign feed_wr = wr & hit(paddr_in, wwt_pkg::OFF_FEED);
    assign soft_clr = (hold_r != '0);
    assign en_rise = wr & hit(paddr_in, wwt_pkg::OFF_CTRL) & ~en_r
                     & pwdata_in[wwt_pkg::CTRL_EN];
    assign tc_wdata = (pwdata_in[23:0] < wwt_pkg::TC_MIN) ? wwt_pkg::TC_MIN
                                                           : pwdata_in[23:0];

    // Feed sequence checking
    assign feed_ok = (feed_st_r == wwt_pkg::FEED_ARMED) & feed_wr
                     & (pwdata_in[7:0] == wwt_pkg::FEED_SECOND);
    assign bad_seq = acc & ~feed_ok & ((feed_st_r == wwt_pkg::FEED_ARMED)
                     | (feed_wr & pwdata_in[7:0] != wwt_pkg::FEED_FIRST));
    assign win_fault = feed_ok & win_en_r & (cnt_r > window_r);
    assign fault_ev = en_r & ~soft_clr & (bad_seq | win_fault);
    assign reload = (feed_ok & ~win_fault) | en_rise;

    // Counter events on each prescaled step
    assign step = en_r & ~soft_clr & tick_sel & (presc_r == wwt_pkg::PRESC_LAST);
    assign timeout_ev = step & (cnt_r == '0);
    assign warn_ev = step & (cnt_r == warn_r);
    assign wd_rst_ev = rst_en_r & (timeout_ev | fault_ev);

    always_comb begin
        int_set = '0;
        int_set[wwt_pkg::INT_WARN] = warn_ev;
        int_set[wwt_pkg::INT_FAULT] = fault_ev;
        int_set[wwt_pkg::INT_TMO] = timeout_ev;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            feed_st_r <= wwt_pkg::FEED_IDLE;
        end else if (acc) begin
            unique case (feed_st_r)
                wwt_pkg::FEED_IDLE: begin
                    if (feed_wr && pwdata_in[7:0] == wwt_pkg::FEED_FIRST) begin
                        feed_st_r <= wwt_pkg::FEED_ARMED;
                    end
                end
                wwt_pkg::FEED_ARMED: begin
                    feed_st_r <= wwt_pkg::FEED_IDLE;
                end
            endcase
        end
    end

    // Control and configuration
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_r <= 1'b0;
            rst_en_r <= 1'b0;
            win_en_r <= 1'b0;
            clk_sel_r <= 1'b0;
            tc_r <= wwt_pkg::TC_RST;
            warn_r <= wwt_pkg::WARN_RST;
            window_r <= wwt_pkg::WINDOW_RST;
            int_mask_r <= '0;
        end else if (soft_clr || wd_rst_ev) begin
            en_r <= 1'b0;
            rst_en_r <= 1'b0;
            win_en_r <= 1'b0;
            clk_sel_r <= 1'b0;
            tc_r <= wwt_pkg::TC_RST;
            warn_r <= wwt_pkg::WARN_RST;
            window_r <= wwt_pkg::WINDOW_RST;
            int_mask_r <= '0;
        end else if (timeout_ev || fault_ev) begin
            en_r <= 1'b0;
        end else if (wr) begin
            if (hit(paddr_in, wwt_pkg::OFF_CTRL)) begin
                en_r <= en_r | pwdata_in[wwt_pkg::CTRL_EN];
                rst_en_r <= pwdata_in[wwt_pkg::CTRL_RST_EN];
                win_en_r <= pwdata_in[wwt_pkg::CTRL_WIN_EN];
                if (!en_r) begin
                    clk_sel_r <= pwdata_in[wwt_pkg::CTRL_CLK_SEL];
                end
            end
            if (hit(paddr_in, wwt_pkg::OFF_TC)) begin
                tc_r <= tc_wdata;
            end
            if (hit(paddr_in, wwt_pkg::OFF_WARN)) begin
                warn_r <= pwdata_in[23:0];
            end
            if (hit(paddr_in, wwt_pkg::OFF_WINDOW)) begin
                window_r <= pwdata_in[23:0];
            end
            if (hit(paddr_in, wwt_pkg::OFF_INT_MASK)) begin
                int_mask_r <= pwdata_in[wwt_pkg::INT_W-1:0];
            end
        end
    end

    // Prescaler and down-counter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_r <= '0;
            cnt_r <= wwt_pkg::CNT_RST;
        end else if (soft_clr) begin
            presc_r <= '0;
            cnt_r <= wwt_pkg::CNT_RST;
        end else begin
            if (reload) begin
                presc_r <= '0;
            end else if (en_r && tick_sel) begin
                presc_r <= presc_r + 2'h1;
            end
            if (reload) begin
                cnt_r <= tc_r;
            end else if (step && cnt_r != '0) begin
                cnt_r <= cnt_r - 24'h000001;
            end
        end
    end

    // Sticky interrupt status, write one to clear; a new event wins
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_stat_r <= '0;
        end else if (soft_clr) begin
            int_stat_r <= '0;
        end else if (wr && hit(paddr_in, wwt_pkg::OFF_INT_STAT)) begin
            int_stat_r <= (int_stat_r & ~pwdata_in[wwt_pkg::INT_W-1:0]) | int_set;
        end else begin
            int_stat_r <= int_stat_r | int_set;
        end
    end

    // Watchdog reset flag survives the chip reset it causes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_flag_r <= 1'b0;
        end else if (wd_rst_ev) begin
            rst_flag_r <= 1'b1;
        end else if (wr && !soft_clr && hit(paddr_in, wwt_pkg::OFF_RST_FLAG)
                     && pwdata_in[0]) begin
            rst_flag_r <= 1'b0;
        end
    end

    // Chip reset pulse, RC oscillator start and flash initialisation
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_r <= '0;
            chip_reset_out <= 1'b0;
            irc_start_out <= 1'b0;
            flash_init_out <= 1'b0;
        end else begin
            flash_init_out <= 1'b0;
            if (wd_rst_ev) begin
                hold_r <= wwt_pkg::RST_HOLD_CYCLES;
                chip_reset_out <= 1'b1;
                irc_start_out <= 1'b1;
            end else if (soft_clr) begin
                hold_r <= hold_r - 5'h01;
                if (hold_r == 5'h01) begin
                    chip_reset_out <= 1'b0;
                    irc_start_out <= 1'b0;
                    flash_init_out <= 1'b1;
                end
            end
        end
    end

    // Read data mux
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        unique case (paddr_in)
            wwt_pkg::OFF_CTRL: begin
                rd_data[wwt_pkg::CTRL_EN] = en_r;
                rd_data[wwt_pkg::CTRL_RST_EN] = rst_en_r;
                rd_data[wwt_pkg::CTRL_WIN_EN] = win_en_r;
                rd_data[wwt_pkg::CTRL_CLK_SEL] = clk_sel_r;
            end
            wwt_pkg::OFF_TC: rd_data[23:0] = tc_r;
            wwt_pkg::OFF_FEED: rd_data = '0;
            wwt_pkg::OFF_COUNT: rd_data[23:0] = cnt_r;
            wwt_pkg::OFF_WARN: rd_data[23:0] = warn_r;
            wwt_pkg::OFF_WINDOW: rd_data[23:0] = window_r;
            wwt_pkg::OFF_INT_STAT: rd_data[wwt_pkg::INT_W-1:0] = int_stat_r;
            wwt_pkg::OFF_INT_MASK: rd_data[wwt_pkg::INT_W-1:0] = int_mask_r;
            wwt_pkg::OFF_RST_FLAG: rd_data[0] = rst_flag_r;
            default: rd_err = 1'b1;
        endcase
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            prdata_out <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & rd_err;
            if (psel_in && penable_in && !pready_out && !pwrite_in) begin
                prdata_out <= rd_data;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_stat_r & int_mask_r);
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // Reset request followed by the held pulse
    sequence s_rst_start;
        wd_rst_ev ##1 chip_reset_out;
    endsequence

    sequence s_rst_held;
        (chip_reset_out && irc_start_out) [*8];
    endsequence

    // Running state in which the tick source selection may not move
    sequence s_run_steady;
        en_r && !soft_clr && !wd_rst_ev;
    endsequence

    // Enabled cycle in which the selected source gives no tick
    sequence s_no_sel_tick;
        en_r && !soft_clr && !reload && !tick_rise[clk_sel_r];
    endsequence

    a_timeout_reset: assert property (timeout_ev && rst_en_r |=> chip_reset_out && !en_r)
        else $error("time-out did not request chip reset");
    a_window_fault: assert property (en_r && !soft_clr && win_fault |=> int_stat_r[1])
        else $error("early feed not flagged as fault");
    a_warn_flag: assert property (warn_ev && !soft_clr |=> int_stat_r[0])
        else $error("warning status not set");
    a_enable_sticky: assert property (en_r && !soft_clr && !timeout_ev && !fault_ev |=> en_r)
        else $error("enable dropped without cause");
    a_fault_irq_only: assert property (fault_ev && !rst_en_r |=> int_stat_r[1] && !chip_reset_out)
        else $error("fault response wrong in interrupt mode");
    a_reset_flag_set: assert property (s_rst_start |-> rst_flag_r)
        else $error("watchdog reset flag not set");
    a_count_step: assert property (step && cnt_r != 0 && !reload |=> cnt_r == $past(cnt_r) - 1)
        else $error("counter did not step down by one");
    a_tc_floor: assert property (tc_r >= 24'h0000ff)
        else $error("time-out count below minimum");
    a_reset_hold: assert property (s_rst_start |-> s_rst_held ##9 !chip_reset_out ##0 flash_init_out)
        else $error("chip reset pulse length wrong");
    a_feed_reload: assert property (feed_ok && !win_fault && !soft_clr |=> cnt_r == $past(tc_r))
        else $error("valid feed did not reload counter");
    a_tick_source: assert property (s_no_sel_tick |=> $stable(presc_r))
        else $error("prescaler moved without a selected tick");
    a_clk_sel_held: assert property (s_run_steady |=> $stable(clk_sel_r))
        else $error("tick source changed while enabled");
    a_bad_seq_fault: assert property (en_r && !soft_clr && bad_seq |=> int_stat_r[1])
        else $error("broken feed sequence not flagged");
    a_flag_kept: assert property (soft_clr && rst_flag_r |=> rst_flag_r)
        else $error("reset flag lost during soft clear");
    a_irc_follows: assert property (chip_reset_out |-> irc_start_out)
        else $error("oscillator start missing during chip reset");
    a_flash_pulse: assert property (flash_init_out |=> !flash_init_out)
        else $error("flash initialisation pulse too long");
    // Interrupt level trails the status and mask by one cycle
    a_irq_level: assert property (|(int_stat_r & int_mask_r) |=> irq_out)
        else $error("interrupt not raised for unmasked status");
endmodule : wwt_timeout_supervisor

`default_nettype wire

// ===== testbench/wwt_sw_model.sv
// Software-side bus master: APB transfers and the two-write feed sequence.
// Assumes the bench calls its tasks and wires its pins to the supervisor's slave.
`default_nettype none

module wwt_sw_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB master side
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [wwt_pkg::ADDR_W-1:0] paddr_out,
    output logic [31:0] pwdata_out,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h00000000;
    end

    // Holds the request until pready; idle bus shows inverted stale values
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        while (rst_n_in !== 1'b1) begin
            @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= addr;
        pwdata_out <= wdata;
        @(posedge clk_sys_in);
        penable_out <= 1'b1;
        // Ready, data and error are taken at the rising edge that completes the access
        @(posedge clk_sys_in);
        while (pready_in !== 1'b1) begin
            @(posedge clk_sys_in);
        end
        rdata = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~addr;
        pwdata_out <= ~wdata;
    endtask : xfer

    task automatic feed(input logic [7:0] first, input logic [7:0] second);
        logic [31:0] d;
        logic e;
        xfer(1'b1, wwt_pkg::OFF_FEED, {24'h000000, first}, d, e);
        xfer(1'b1, wwt_pkg::OFF_FEED, {24'h000000, second}, d, e);
    endtask : feed
endmodule : wwt_sw_model

`default_nettype wire

// ===== testbench/windowed_watchdog_timer_bench.sv
// Self-checking bench for the timeout supervisor: bus, ticks, feeds, resets.
// Assumes the software model drives APB and this bench drives the tick pins.
`default_nettype none

module windowed_watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rc_pin = 1'b0;
    logic wo_pin = 1'b0;
    logic irq_out, chip_reset_out, irc_start_out, flash_init_out;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 91654;
    int cycles = 0;
    int rst_len = 0;
    int irc_bad = 0;
    int flash_n = 0;
    logic [31:0] v, d;
    logic e;

    always #4 clk_sys_in = ~clk_sys_in;

    wwt_timeout_supervisor dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .internal_rc_oscillator_in(rc_pin), .dedicated_watch_oscillator_in(wo_pin),
        .irq_out(irq_out), .chip_reset_out(chip_reset_out), .irc_start_out(irc_start_out),
        .flash_init_out(flash_init_out));

    wwt_sw_model sw (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

    // Measures each chip reset pulse and its companion outputs
    always @(negedge clk_sys_in) begin
        if (chip_reset_out === 1'b1) rst_len <= rst_len + 1;
        if (irc_start_out !== chip_reset_out) irc_bad <= irc_bad + 1;
        if (flash_init_out === 1'b1) flash_n <= flash_n + 1;
    end

    function automatic logic [31:0] tc_exp(input logic [31:0] val);
        return (val[23:0] < 24'h0000ff) ? 32'h000000ff : {8'h00, val[23:0]};
    endfunction : tc_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The interrupt output follows a status or mask write one edge later; it is read at the second edge
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, irq_out}, {31'h0, exp});
    endtask : chk_irq

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        sw.xfer(1'b1, a, dat, d, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        sw.xfer(1'b0, a, 32'h00000000, d, e);
        chk(d, exp);
    endtask : rd

    task automatic ticks(input int n, input logic watch);
        repeat (n) begin
            @(posedge clk_sys_in);
            if (watch) wo_pin <= 1'b1;
            else rc_pin <= 1'b1;
            repeat (4) @(posedge clk_sys_in);
            rc_pin <= 1'b0;
            wo_pin <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
        end
        repeat (8) @(posedge clk_sys_in);
    endtask : ticks

    task automatic clear_mon();
        @(posedge clk_sys_in);
        rst_len = 0;
        irc_bad = 0;
        flash_n = 0;
    endtask : clear_mon

    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        // Reset values, unmapped offset, read-only and write-only places
        rd(wwt_pkg::OFF_CTRL, 32'h0);
        rd(wwt_pkg::OFF_TC, 32'hff);
        rd(wwt_pkg::OFF_COUNT, 32'hff);
        rd(wwt_pkg::OFF_WARN, 32'h0);
        rd(wwt_pkg::OFF_WINDOW, 32'hffffff);
        rd(wwt_pkg::OFF_INT_STAT, 32'h0);
        rd(wwt_pkg::OFF_INT_MASK, 32'h0);
        rd(wwt_pkg::OFF_RST_FLAG, 32'h0);
        rd(wwt_pkg::OFF_FEED, 32'h0);
        wr(wwt_pkg::OFF_COUNT, 32'h1234);
        rd(wwt_pkg::OFF_COUNT, 32'hff);
        rd(8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Random field values, first a count below the minimum
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 32'h10 : $random(seed);
            wr(wwt_pkg::OFF_WARN, v);
            rd(wwt_pkg::OFF_WARN, {8'h00, v[23:0]});
            wr(wwt_pkg::OFF_TC, v);
            rd(wwt_pkg::OFF_TC, tc_exp(v));
        end
        // Tick select, prescaler, locked enable, feed reload
        wr(wwt_pkg::OFF_WARN, 32'hfd);
        wr(wwt_pkg::OFF_TC, 32'h100);
        wr(wwt_pkg::OFF_CTRL, 32'h9);
        rd(wwt_pkg::OFF_COUNT, 32'h100);
        ticks(8, 1'b0);
        rd(wwt_pkg::OFF_COUNT, 32'h100);
        ticks(8, 1'b1);
        rd(wwt_pkg::OFF_COUNT, 32'hfe);
        wr(wwt_pkg::OFF_CTRL, 32'h0);
        rd(wwt_pkg::OFF_CTRL, 32'h9);
        sw.feed(8'haa, 8'h55);
        rd(wwt_pkg::OFF_COUNT, 32'h100);
        // Warning on the fourth step, then masked and unmasked fault
        wr(wwt_pkg::OFF_INT_MASK, 32'h5);
        ticks(15, 1'b1);
        chk({31'h0, irq_out}, 32'h0);
        ticks(1, 1'b1);
        chk({31'h0, irq_out}, 32'h1);
        rd(wwt_pkg::OFF_INT_STAT, 32'h1);
        wr(wwt_pkg::OFF_INT_STAT, 32'h1);
        chk_irq(1'b0);
        sw.feed(8'haa, 8'h12);
        rd(wwt_pkg::OFF_INT_STAT, 32'h2);
        chk({31'h0, irq_out}, 32'h0);
        rd(wwt_pkg::OFF_CTRL, 32'h8);
        wr(wwt_pkg::OFF_INT_MASK, 32'h7);
        chk_irq(1'b1);
        wr(wwt_pkg::OFF_INT_STAT, 32'h2);
        chk_irq(1'b0);
        // Window: feed accepted at the bound, refused above it
        wr(wwt_pkg::OFF_WINDOW, 32'hfe);
        wr(wwt_pkg::OFF_CTRL, 32'h5);
        ticks(8, 1'b0);
        sw.feed(8'haa, 8'h55);
        rd(wwt_pkg::OFF_COUNT, 32'h100);
        rd(wwt_pkg::OFF_INT_STAT, 32'h0);
        ticks(4, 1'b0);
        sw.feed(8'haa, 8'h55);
        rd(wwt_pkg::OFF_INT_STAT, 32'h2);
        rd(wwt_pkg::OFF_COUNT, 32'hff);
        wr(wwt_pkg::OFF_INT_STAT, 32'h2);
        // Broken feed sequence in reset mode
        clear_mon();
        wr(wwt_pkg::OFF_CTRL, 32'h3);
        wr(wwt_pkg::OFF_FEED, 32'haa);
        rd(wwt_pkg::OFF_TC, 32'h100);
        repeat (30) @(posedge clk_sys_in);
        chk(rst_len, 32'd16);
        chk(irc_bad, 32'd0);
        chk(flash_n, 32'd1);
        rd(wwt_pkg::OFF_RST_FLAG, 32'h1);
        rd(wwt_pkg::OFF_CTRL, 32'h0);
        rd(wwt_pkg::OFF_TC, 32'hff);
        wr(wwt_pkg::OFF_RST_FLAG, 32'h1);
        rd(wwt_pkg::OFF_RST_FLAG, 32'h0);
        // Time-out exactly at (TC+1)*4 ticks
        clear_mon();
        wr(wwt_pkg::OFF_CTRL, 32'h3);
        ticks(1023, 1'b0);
        chk(rst_len, 32'd0);
        rd(wwt_pkg::OFF_COUNT, 32'h0);
        ticks(1, 1'b0);
        repeat (30) @(posedge clk_sys_in);
        chk(rst_len, 32'd16);
        chk(flash_n, 32'd1);
        rd(wwt_pkg::OFF_RST_FLAG, 32'h1);
        close_out();
    end
endmodule : windowed_watchdog_timer_bench

`default_nettype wire
